/* File: logic/bfs_defines.svh */
// timing counts and field values for the buck supervisor
// assumes a single 50 mhz clock and an active-low asynchronous reset
`ifndef BFS_DEFINES_SVH
`define BFS_DEFINES_SVH
`define BFS_CLK_HZ        50000000
`define BFS_OSC_HZ        200000
`define BFS_OSC_DIV       (`BFS_CLK_HZ / `BFS_OSC_HZ)
`define BFS_SYNC_MAX_HZ   400000
`define BFS_SYNC_MIN_DIV  (`BFS_CLK_HZ / `BFS_SYNC_MAX_HZ)
`define BFS_SS_COUNTS     4096
`define BFS_DT_MAX_NS     100
`define BFS_CLK_NS        20
`define BFS_DT_CYC        (`BFS_DT_MAX_NS / `BFS_CLK_NS)
`define BFS_RAMP_FULL     8'hff
`endif

/* File: logic/bfs_osc.sv */
// switching oscillator: internal divider or faster external sync
// assumes sync pin already passed two flip-flops
`timescale 1ns/10ps
`include "bfs_defines.svh"
module bfs_osc #(
   parameter int DIV = `BFS_OSC_DIV,
   parameter int MIN_DIV = `BFS_SYNC_MIN_DIV
)(
   input  wire logic clk_i,
   input  wire logic resetn_i,
   input  wire logic sync_i,
   output logic      tick_o
);
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic        sync_d_reg;
   logic        tick_reg;
   logic        tick_next;
   logic        rise;

   initial
   begin
      if (DIV < 2 || DIV > 65535 || MIN_DIV > DIV)
         $error("bfs_osc: divider out of range");
   end

   // a sync edge restarts the cycle only if the period is legal (<=400 kHz)
   always_comb
   begin
      rise = sync_i && !sync_d_reg;
      tick_next = 1'b0;
      cnt_next = cnt_reg + 16'h0001;
      if ((rise && cnt_reg >= 16'(MIN_DIV - 1)) ||
          cnt_reg >= 16'(DIV - 1))
      begin
         tick_next = 1'b1;
         cnt_next = 16'h0000;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt_reg <= 16'h0000;
         sync_d_reg <= 1'b0;
         tick_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         sync_d_reg <= sync_i;
         tick_reg <= tick_next;
      end
   end
   assign tick_o = tick_reg;
endmodule : bfs_osc

/* File: logic/bfs_pkg.sv */
// types shared by the buck supervisor files
// assumes the defines header is compiled alongside
package bfs_pkg;
   typedef enum logic [1:0] {BFS_SOFTSTART, BFS_RUN, BFS_LATCHED} bfs_mode_t;
   typedef enum logic [1:0] {BFS_OFF, BFS_HIGH, BFS_DEAD, BFS_LOW} bfs_phase_t;
endpackage : bfs_pkg

/* File: logic/bfs_supervisor.sv */
// fault, soft-start and switch-command logic for one buck channel
// assumes comparator inputs are asynchronous; reset is power-on only
`timescale 1ns/10ps
`include "bfs_defines.svh"
module bfs_supervisor
   import bfs_pkg::*;
#(
   parameter int SS_COUNTS = `BFS_SS_COUNTS
)(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       sync_i,
   input  wire logic       low_output_boost_comparator_i,
   input  wire logic       output_undervoltage_fault_i,
   input  wire logic       output_overvoltage_fault_i,
   input  wire logic       in_regulation_i,
   input  wire logic       pwm_trip_i,
   input  wire logic       ilim_pos_i,
   input  wire logic       ilim_neg_i,
   input  wire logic       sw_zero_i,
   input  wire logic [7:0] ss_ramp_i,
   output logic            high_on_o,
   output logic            low_on_o,
   output logic            fault_latched_o,
   output logic            softstart_o
);
   import bfs_pkg::*;
   localparam int DT = (`BFS_DT_CYC < 1) ? 1 : `BFS_DT_CYC;

   initial
   begin
      if (SS_COUNTS < 2 || SS_COUNTS > 65535)
         $error("bfs_supervisor: soft-start count out of range");
   end

   // two-flop synchronisers; first stage read only by the second
   logic [9:0] s1_reg;
   logic [9:0] s2_reg;
   logic [9:0] raw;
   assign raw = {sync_i, low_output_boost_comparator_i,
                 output_undervoltage_fault_i, output_overvoltage_fault_i,
                 in_regulation_i, pwm_trip_i, ilim_pos_i, ilim_neg_i,
                 sw_zero_i, 1'b0};
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s1_reg <= 10'h000;
         s2_reg <= 10'h000;
      end
      else
      begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
      end
   end
   logic sync_s, low_s, uv_s, ov_s, reg_s, trip_s, ipos_s, ineg_s, zero_s;
   assign {sync_s, low_s, uv_s, ov_s, reg_s, trip_s, ipos_s, ineg_s,
           zero_s} = s2_reg[9:1];

   // ramp pins sampled the same way; a torn sample only moves one pulse
   logic [7:0] ramp1_reg;
   logic [7:0] ramp2_reg;
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ramp1_reg <= 8'h00;
         ramp2_reg <= 8'h00;
      end
      else
      begin
         ramp1_reg <= ss_ramp_i;
         ramp2_reg <= ramp1_reg;
      end
   end

   logic tick;
   bfs_osc u_osc (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .sync_i   (sync_s),
      .tick_o   (tick)
   );

   // mode: soft-start, run, latched; latched has no exit but reset
   bfs_mode_t   mode_reg, mode_next;
   logic [15:0] ss_cnt_reg, ss_cnt_next;
   always_comb
   begin
      mode_next = mode_reg;
      ss_cnt_next = ss_cnt_reg;
      case (mode_reg)
         BFS_SOFTSTART: // undervoltage not read here
         begin
            if (ov_s)
               mode_next = BFS_LATCHED;
            else if (reg_s)
               mode_next = BFS_RUN;
            else if (tick)
            begin
               ss_cnt_next = ss_cnt_reg + 16'h0001;
               if (ss_cnt_reg == 16'(SS_COUNTS - 1))
                  mode_next = BFS_LATCHED;
            end
         end
         BFS_RUN:
            if (uv_s || ov_s)
               mode_next = BFS_LATCHED;
         BFS_LATCHED:
            mode_next = BFS_LATCHED;
         default:
            mode_next = BFS_LATCHED;
      endcase
   end
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         mode_reg <= BFS_SOFTSTART;
         ss_cnt_reg <= 16'h0000;
      end
      else
      begin
         mode_reg <= mode_next;
         ss_cnt_reg <= ss_cnt_next;
      end
   end

   // switch phases; dead phase between the two commands
   bfs_phase_t phase_reg, phase_next;
   logic [7:0] pw_reg, pw_next;
   logic [3:0] dt_reg, dt_next;
   logic       hi_next, lo_next, hi_reg, lo_reg;
   logic       boost;
   logic       hop_next, hop_reg;
   always_comb
   begin
      boost = low_s && mode_reg == BFS_RUN;
      phase_next = phase_reg;
      pw_next = pw_reg + 8'h01;
      dt_next = dt_reg;
      case (phase_reg)
         BFS_OFF:
            if (tick || hop_reg)
            begin
               phase_next = BFS_HIGH;
               pw_next = 8'h00;
            end
         BFS_HIGH:
            // ramp width only during soft-start; boost overrides trips
            if (!boost && (ipos_s || trip_s ||
                (mode_reg == BFS_SOFTSTART && pw_reg >= ramp2_reg)))
            begin
               phase_next = BFS_DEAD;
               dt_next = 4'h0;
            end
         BFS_DEAD:
         begin
            dt_next = dt_reg + 4'h1;
            if (zero_s || dt_reg >= 4'(DT - 1))
               phase_next = BFS_LOW;
         end
         BFS_LOW:
            if (tick)
            begin
               phase_next = BFS_HIGH;
               pw_next = 8'h00;
            end
            else if (ineg_s)
               phase_next = BFS_OFF;
         default:
            phase_next = BFS_OFF;
      endcase
      if (mode_next == BFS_LATCHED)
         phase_next = BFS_LOW;
      else if (boost)
         phase_next = BFS_HIGH;
      // break before make: a new turn-on waits a cycle with both off
      hi_next = phase_next == BFS_HIGH && !lo_reg;
      lo_next = phase_next == BFS_LOW && !hi_reg;
      // deferred turn-on is kept, else every other pulse would be lost
      hop_next = phase_next == BFS_HIGH && lo_reg;
      if (hop_next)
         phase_next = BFS_OFF;
      if (phase_next == BFS_LOW && hi_reg && mode_next != BFS_LATCHED)
         phase_next = BFS_DEAD;
   end
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         phase_reg <= BFS_OFF;
         pw_reg <= 8'h00;
         dt_reg <= 4'h0;
         hi_reg <= 1'b0;
         lo_reg <= 1'b0;
         hop_reg <= 1'b0;
      end
      else
      begin
         phase_reg <= phase_next;
         pw_reg <= pw_next;
         dt_reg <= dt_next;
         hi_reg <= hi_next;
         lo_reg <= lo_next;
         hop_reg <= hop_next;
      end
   end

   // status outputs registered alongside the switch commands
   logic flt_reg, ss_reg;
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         flt_reg <= 1'b0;
         ss_reg <= 1'b1;
      end
      else
      begin
         flt_reg <= mode_next == BFS_LATCHED;
         ss_reg <= mode_next == BFS_SOFTSTART;
      end
   end
   assign high_on_o = hi_reg;
   assign low_on_o = lo_reg;
   assign fault_latched_o = flt_reg;
   assign softstart_o = ss_reg;

   property p_never_both;
      @(posedge clk_i) disable iff (!resetn_i) !(hi_reg && lo_reg);
   endproperty
   a_never_both: assert property (p_never_both)
      else $error("both switches on");

   property p_latch_hold;
      @(posedge clk_i) disable iff (!resetn_i) flt_reg |=> flt_reg;
   endproperty
   a_latch_hold: assert property (p_latch_hold)
      else $error("fault latch released");

   property p_latch_low;
      @(posedge clk_i) disable iff (!resetn_i)
         flt_reg ##1 flt_reg |-> ##1 (lo_reg && !hi_reg);
   endproperty
   a_latch_low: assert property (p_latch_low)
      else $error("latched state not low side on");

   property p_ov_latch;
      @(posedge clk_i) disable iff (!resetn_i)
         ov_s |=> flt_reg;
   endproperty
   a_ov_latch: assert property (p_ov_latch)
      else $error("overvoltage did not latch");

   property p_uv_run;
      @(posedge clk_i) disable iff (!resetn_i)
         uv_s && mode_reg == BFS_RUN |=> flt_reg;
   endproperty
   a_uv_run: assert property (p_uv_run)
      else $error("undervoltage did not latch");

   property p_uv_ss;
      @(posedge clk_i) disable iff (!resetn_i)
         mode_reg == BFS_SOFTSTART && !ov_s && !tick |=> !flt_reg;
   endproperty
   a_uv_ss: assert property (p_uv_ss)
      else $error("latched during soft-start");

   property p_boost;
      @(posedge clk_i) disable iff (!resetn_i)
         (boost && !uv_s && !ov_s) ##1 (boost && !uv_s && !ov_s)
            |=> hi_reg && !lo_reg;
   endproperty
   a_boost: assert property (p_boost)
      else $error("boost did not force high side");

   property p_ipos;
      @(posedge clk_i) disable iff (!resetn_i)
         phase_reg == BFS_HIGH && ipos_s && !boost |=> !hi_reg;
   endproperty
   a_ipos: assert property (p_ipos)
      else $error("high side stayed on past limit");

   property p_dead;
      @(posedge clk_i) disable iff (!resetn_i)
         phase_reg == BFS_DEAD |-> ##[1:6] (lo_reg || hi_reg);
   endproperty
   a_dead: assert property (p_dead)
      else $error("low side late after dead time");

   c_boost: cover property (@(posedge clk_i) boost ##1 hi_reg);
   c_run: cover property (@(posedge clk_i) mode_reg == BFS_RUN);
   c_latch: cover property (@(posedge clk_i) !flt_reg ##1 flt_reg);
endmodule : bfs_supervisor

/* File: sim/bfs_bridge_model.sv */
// half-bridge and switch-node stand-in for the buck supervisor bench
// assumes the switch commands are registered levels on clk_i
`timescale 1ns/10ps
module bfs_bridge_model (
   input  wire logic clk_i,
   input  wire logic high_on_i,
   input  wire logic low_on_i,
   input  wire logic slow_i,
   output logic      sw_zero_o
);
   logic [2:0] dly_reg = 3'h7;
   // node decays one cycle after high side opens; slow never gets there
   always_ff @(posedge clk_i)
   begin
      if (high_on_i)
         dly_reg <= 3'h0;
      else if (dly_reg != 3'h7)
         dly_reg <= dly_reg + 3'h1;
   end
   // slow mode leaves only the dead-time limit to end the gap
   assign sw_zero_o = !high_on_i && (low_on_i || (!slow_i && dly_reg >= 3'h1));
endmodule : bfs_bridge_model

/* File: sim/bfs_supervisor_tb.sv */
// self-checking bench for the buck supervisor
// assumes soft-start count shortened to 4 ticks, 250-cycle oscillator
`timescale 1ns/10ps
module bfs_supervisor_tb;
   logic clk_i, resetn_i, sync_i, boost, uv, ov, in_reg, trip, ipos, ineg;
   logic slow, sw_zero, high_on_o, low_on_o, fault_o, ss_o, high_d;
   logic [7:0] ramp;
   int err_total, tests_run, cyc, n, i;
   logic [2:0] rows [4] = '{3'b000, 3'b101, 3'b011, 3'b111};
   bfs_supervisor #(.SS_COUNTS(4)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .sync_i(sync_i), .low_output_boost_comparator_i(boost),
      .output_undervoltage_fault_i(uv), .output_overvoltage_fault_i(ov),
      .in_regulation_i(in_reg), .pwm_trip_i(trip), .ilim_pos_i(ipos),
      .ilim_neg_i(ineg), .sw_zero_i(sw_zero), .ss_ramp_i(ramp),
      .high_on_o(high_on_o), .low_on_o(low_on_o), .fault_latched_o(fault_o),
      .softstart_o(ss_o));
   bfs_bridge_model bridge (.clk_i(clk_i), .high_on_i(high_on_o),
      .low_on_i(low_on_o), .slow_i(slow), .sw_zero_o(sw_zero));
   initial
   begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   task automatic chk(input string nm, input logic [8:0] seen,
      input logic [8:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk
   task end_of_test;
      if (err_total == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_of_test
   // cycles until the next high-side turn-on, bounded
   task wr(output int k);
      k = 0;
      do
      begin
         @(posedge clk_i);
         #1;
         k++;
      end
      while (!(high_on_o === 1'b1 && high_d === 1'b0) && k < 700);
   endtask : wr
   task rst;
      @(posedge clk_i);
      {resetn_i, sync_i, boost, uv, ov, in_reg, trip, ipos, ineg} <= 9'h0;
      ramp <= 8'h0a;
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
   endtask : rst
   task to_run;
      rst;
      in_reg <= 1'b1;
      ramp <= 8'hff;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ss_o !== 1'b0 && n < 700);
      chk("softstart", ss_o, 0);
   endtask : to_run
   always @(posedge clk_i)
   begin
      high_d <= high_on_o;
      cyc++;
      // overlap would short the input supply
      if (resetn_i === 1'b1)
         chk("overlap", high_on_o & low_on_o, 0);
      if (cyc == 40000)
      begin
         err_total++;
         end_of_test;
      end
   end
   initial
   begin
      {resetn_i, sync_i, boost, uv, ov, in_reg, trip, ipos, ineg} = 9'h0;
      {ramp, slow, err_total, tests_run, cyc} = '0;
      // fault cases as rows: uv, ov, expected latch
      for (i = 0; i < 4; i++)
      begin
         to_run;
         uv <= rows[i][2];
         ov <= rows[i][1];
         repeat (10) @(posedge clk_i);
         chk("fault", fault_o, rows[i][0]);
         if (rows[i][0])
            chk("latched_sw", {high_on_o, low_on_o}, 2'b01);
      end
      rst;
      #1;
      chk("reset_out", {high_on_o, low_on_o, fault_o, ss_o}, 4'h1);
      boost <= 1'b1;
      uv <= 1'b1;
      wr(n);
      n = 0;
      while (high_on_o === 1'b1 && n < 300)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk("ss_width", n <= 11, 1);
      chk("ss_uv", fault_o, 0);
      repeat (1300) @(posedge clk_i);
      chk("ss_timeout", fault_o, 1);
      {in_reg, boost, uv} <= 3'h4;
      repeat (300) @(posedge clk_i);
      chk("hold", {fault_o, high_on_o, low_on_o}, 3'b101);
      to_run;
      trip <= 1'b1;
      slow <= 1'b1;
      wr(n);
      wr(n);
      wr(n);
      chk("period", n, 250);
      while (high_on_o === 1'b1)
         @(posedge clk_i);
      n = 0;
      while (low_on_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk("dead", n inside {[2:7]}, 1);
      ineg <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      chk("neg_lim", low_on_o, 0);
      {ineg, trip} <= 2'h0;
      wr(n);
      ipos <= 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      chk("pos_lim", high_on_o, 0);
      {ipos, trip, boost} <= 3'h1;
      repeat (8) @(posedge clk_i);
      n = 0;
      repeat (600)
      begin
         @(posedge clk_i);
         if ({high_on_o, low_on_o} === 2'b10)
            n++;
      end
      chk("boost", n, 600);
      {boost, trip} <= 2'h1;
      fork
         repeat (6)
         begin
            @(posedge clk_i);
            sync_i <= 1'b1;
            repeat (10) @(posedge clk_i);
            sync_i <= 1'b0;
            repeat (139) @(posedge clk_i);
         end
         begin
            repeat (310) @(posedge clk_i);
            wr(n);
            wr(n);
         end
      join
      chk("sync", n, 150);
      // fast node: zero crossing must end the gap before the limit
      slow <= 1'b0;
      wr(n);
      while (high_on_o === 1'b1)
         @(posedge clk_i);
      n = 0;
      while (low_on_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk("zero", n inside {[1:3]}, 1);
      end_of_test;
   end
endmodule : bfs_supervisor_tb
